//--- sync_stage.sv
module sync_stage #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // ****************************************
    // Two flip-flop synchroniser
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

//--- testbench.sv
module testbench
    import wdog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Stimulus signals
    // ****************************************
    localparam int LIMIT = 95000;
    localparam int TICK = 8;
    logic clk;
    logic rst;
    fuses_s fuses;
    logic ext_reset_n;
    logic supply_low;
    logic osc_128k;
    logic comparator_bandgap_select;
    logic converter_enable;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic core_reset;
    logic wdt_irq;
    logic vref_enable;
    logic [2:0] osc_div = 3'h0;
    int cycles = 0;
    int mismatches = 0;
    int num_checks = 0;
    int n;

    wdog_reset_ctrl i_dut (
        .clk(clk),
        .rst(rst),
        .fuses(fuses),
        .ext_reset_n(ext_reset_n),
        .supply_low(supply_low),
        .osc_128k(osc_128k),
        .comparator_bandgap_select(comparator_bandgap_select),
        .converter_enable(converter_enable),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .core_reset(core_reset),
        .wdt_irq(wdt_irq),
        .vref_enable(vref_enable)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // The oscillator runs far faster than the real part so that a full
    // watchdog period fits in a short run; one tick is TICK clocks.
    always @(posedge clk) begin
        osc_div <= osc_div + 3'h1;
        osc_128k <= osc_div[2];
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic inr(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction

    task automatic run(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wait_until(input int sel, input logic lvl, input int lim,
                              output int k);
        k = 0;
        while (k < lim && (sel == 0 ? core_reset : wdt_irq) !== lvl) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    task automatic release_time();
        wait_until(0, 1'b0, 4000, n);
        check(inr(n, STARTUP_CYC - 2, STARTUP_CYC + 6), 1'b1);
        @(posedge clk);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        run(16);
        rst <= 1'b0;
        release_time();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        fuses = fuses_s'(3'b010);
        ext_reset_n = 1'b1;
        supply_low = 1'b0;
        comparator_bandgap_select = 1'b0;
        converter_enable = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        do_reset();
        comparator_bandgap_select <= 1'b1;
        run(3);
        check(vref_enable, 1'b1);
        comparator_bandgap_select <= 1'b0;
        converter_enable <= 1'b1;
        run(3);
        check(vref_enable, 1'b1);
        converter_enable <= 1'b0;
        run(3);
        check(vref_enable, 1'b0);
        fuses <= fuses_s'(3'b011);
        run(5);
        check(vref_enable, 1'b1);
        @(posedge clk);
        ext_reset_n <= 1'b0;
        #2;
        check(core_reset, 1'b1);
        run(5);
        ext_reset_n <= 1'b1;
        release_time();
        supply_low <= 1'b1;
        run(BOD_MIN_CYC / 2);
        supply_low <= 1'b0;
        wait_until(0, 1'b1, 80, n);
        check(n, 80);
        @(posedge clk);
        supply_low <= 1'b1;
        wait_until(0, 1'b1, 150, n);
        check(inr(n, BOD_MIN_CYC, BOD_MIN_CYC + 6), 1'b1);
        run(20);
        supply_low <= 1'b0;
        release_time();
        // Level 2 protection; the fuse is a strap, so reset after moving it.
        fuses <= fuses_s'(3'b111);
        do_reset();
        rd_chk(ADDR_CTRL, 8'h08);
        wr_reg(ADDR_CTRL, 8'h01);
        rd_chk(ADDR_CTRL, 8'h08);
        wr_reg(ADDR_CTRL, 8'h18);
        wr_reg(ADDR_CTRL, 8'h01);
        rd_chk(ADDR_CTRL, 8'h09);
        wr_reg(ADDR_CTRL, 8'h18);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 8'h08);
        @(posedge clk);
        fuses <= fuses_s'(3'b011);
        do_reset();
        rd_chk(ADDR_CTRL, RESET_VALUE);
        rd_chk(2'h3, 8'h00);
        wr_reg(ADDR_CTRL, 8'h08);
        rd_chk(ADDR_CTRL, 8'h08);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 8'h08);
        wr_reg(ADDR_CTRL, 8'h18);
        rd_chk(ADDR_CTRL, 8'h18);
        run(6);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 8'h08);
        wr_reg(ADDR_CTRL, 8'h18);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 8'h00);
        wr_reg(ADDR_CTRL, 8'h40);
        wait_until(1, 1'b1, 2100 * TICK, n);
        check(inr(n, 2044 * TICK, 2052 * TICK), 1'b1);
        check(core_reset, 1'b0);
        rd_chk(ADDR_CTRL, 8'hc0);
        wr_reg(ADDR_CTRL, 8'hc0);
        run(2);
        check(wdt_irq, 1'b0);
        wr_reg(ADDR_CTRL, 8'h00);
        // A restart three quarters of the way through must push the timeout a whole period out.
        wr_reg(ADDR_CTRL, 8'h48);
        run(1500 * TICK);
        wr_reg(ADDR_RESTART, 8'h00);
        run(1000 * TICK);
        rd_chk(ADDR_CTRL, 8'h48);
        run(1100 * TICK);
        rd_chk(ADDR_CTRL, 8'h88);
        check(wdt_irq, 1'b1);
        wait_until(0, 1'b1, 2100 * TICK, n);
        check(n < 2100 * TICK, 1'b1);
        release_time();
        rd_chk(ADDR_CTRL, 8'h00);
        check(wdt_irq, 1'b0);
        report_and_stop();
    end
endmodule

//--- wdog_pkg.sv
package wdog_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int OSC_KHZ = 128;
    localparam int STARTUP_TIMEOUT_NS = 64000;
    localparam int STARTUP_CYC = (STARTUP_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int BOD_MIN_NS = 2000;
    localparam int BOD_MIN_CYC = (BOD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int TOUT_W = 12;
    localparam int BOD_W = 7;
    localparam logic [TOUT_W-1:0] TOUT_LAST = TOUT_W'(STARTUP_CYC - 1);
    localparam logic [BOD_W-1:0] BOD_LAST = BOD_W'(BOD_MIN_CYC - 1);
    localparam logic [1:0] UNLOCK_LAST = 2'h3;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_RESTART = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam int CTRL_FLAG = 7;
    localparam int CTRL_IE = 6;
    localparam int CTRL_P3 = 5;
    localparam int CTRL_UNLOCK = 4;
    localparam int CTRL_EN = 3;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // ****************************************
    // Watchdog period
    // ****************************************
    localparam int CNT_W = 21;
    localparam logic [CNT_W-1:0] PERIOD_BASE = 21'h000800;
    localparam logic [3:0] PERIOD_MAX = 4'h9;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic safety_level_fuse;
        logic ext_reset_en;
        logic brownout_level_fuse;
    } fuses_s;

    typedef struct packed {
        logic flag;
        logic timeout_interrupt_enable;
        logic [3:0] period_select_bits;
        logic change_unlock_bit;
        logic watchdog_enable_bit;
    } wdctl_s;

    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_IRQ = 2'b01,
        ACT_RST = 2'b10
    } action_e;

endpackage

//--- wdog_reset_ctrl.sv
// Operation
// R1: Low reset pin with the function enabled forces reset without a clock.
// R2: After the pin rises, core stays in reset until start-up timeout ends.
// R3: Sustained supply-low asserts reset; release follows the start-up timeout.
// R4: Supply-low shorter than the brownout minimum duration is ignored.
// R5: Watchdog reset is one clock pulse; timeout counting starts after it.
// R6: Reference enable is brownout fuse OR bandgap select OR converter enable.
// R7: Watchdog counter advances on ticks of the 128 kHz oscillator.
// R8: Restart, disable and any device reset clear the watchdog counter.
// R9: Ten periods; an unrestarted timeout resets the device.
// R10: Watchdog can raise an interrupt instead of a reset.
// R11: Safety fuse chooses level 1 or level 2 protection.
// R12: Level 1 accepts a write setting enable with no unlock.
// R13: Level 1 disables only via unlock write then update within four cycles.
// R14: Level 2 keeps the watchdog running; enable reads as one.
// R15: Level 2 period change needs the unlock sequence; enable value ignored.
// R16: Enable and interrupt-enable together select the timeout action.
// R17: Timeout with enable set clears interrupt-enable.
// R18: Unlock bit self-clears four clock cycles after being set.
// R19: Period is 2048 oscillator cycles doubling to 1048576; reserved clamps.
// R20: Oscillator edges and events cross into the system clock safely.
// R21: All reset sources combine; release only when idle and timeout expired.
module wdog_reset_ctrl
    import wdog_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fuses_s fuses,
    input wire logic ext_reset_n,
    input wire logic supply_low,
    input wire logic osc_128k,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic core_reset,
    output logic wdt_irq,
    output logic vref_enable
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [5:0] pins_s;
    fuses_s fz;
    logic ext_n_s;
    logic low_s;
    logic osc_s;
    logic osc_d_reg;
    logic osc_tick;

    sync_stage #(
        .W(6)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({fuses, ext_reset_n, supply_low, osc_128k}),
        .q(pins_s)
    );

    assign fz = fuses_s'(pins_s[5:3]);
    assign ext_n_s = pins_s[2];
    assign low_s = pins_s[1];
    assign osc_s = pins_s[0];

    // The oscillator is sampled as a pin; its rising edge becomes a tick.
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_d_reg <= 1'b0;
        end else begin
            osc_d_reg <= osc_s;
        end
    end

    assign osc_tick = osc_s && !osc_d_reg; // [R7] [R20]

    // ****************************************
    // Register decode
    // ****************************************
    wdctl_s ctl_reg;
    wdctl_s ctl_next;
    logic [1:0] ucnt_reg;
    logic core_reset_reg;
    logic wr_ctrl;
    logic restart_wr;
    logic open_seq;
    logic second_wr;
    logic level2;
    logic en_eff;
    logic dev_rst;
    logic [3:0] wr_period;
    action_e act;

    assign wr_ctrl = wr && (addr == ADDR_CTRL);
    assign restart_wr = wr && (addr == ADDR_RESTART);
    assign level2 = fz.safety_level_fuse; // [R11]
    assign en_eff = ctl_reg.watchdog_enable_bit || level2; // [R14]
    assign dev_rst = rst || core_reset_reg;
    assign wr_period = {wdata[CTRL_P3], wdata[2:0]};
    assign open_seq = wr_ctrl && wdata[CTRL_UNLOCK]
        && wdata[CTRL_EN]; // [R13] [R15]
    assign second_wr = wr_ctrl && ctl_reg.change_unlock_bit
        && !wdata[CTRL_UNLOCK]; // [R13] [R15]

    // ****************************************
    // Timeout action
    // ****************************************
    always_comb begin
        unique case ({en_eff, ctl_reg.timeout_interrupt_enable}) // [R16]
            2'b00: act = ACT_NONE;
            2'b01: act = ACT_IRQ; // [R10]
            2'b10: act = ACT_RST;
            2'b11: act = ACT_IRQ;
        endcase
    end

    // ****************************************
    // Watchdog counter
    // ****************************************
    logic [CNT_W-1:0] wcnt_reg;
    logic [3:0] code_eff;
    logic [CNT_W-1:0] period_last;
    logic active;
    logic timeout;
    logic wdt_pulse_reg;

    assign code_eff = (ctl_reg.period_select_bits > PERIOD_MAX) ?
        PERIOD_MAX : ctl_reg.period_select_bits; // [R19]
    assign period_last = (PERIOD_BASE << code_eff) - 21'h1; // [R9] [R19]
    assign active = (act != ACT_NONE);
    // A shortened period catches a counter already past the new end.
    assign timeout = osc_tick && active && (wcnt_reg >= period_last);

    always_ff @(posedge clk) begin
        if (dev_rst || restart_wr || !active) begin
            wcnt_reg <= '0; // [R8]
        end else if (osc_tick) begin
            wcnt_reg <= timeout ? '0 : wcnt_reg + 21'h1; // [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            wdt_pulse_reg <= 1'b0;
        end else begin
            wdt_pulse_reg <= timeout && (act == ACT_RST); // [R5] [R9]
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_comb begin
        ctl_next = ctl_reg;
        if (ctl_reg.change_unlock_bit && (ucnt_reg == 2'h0)) begin
            ctl_next.change_unlock_bit = 1'b0; // [R18]
        end
        if (wr_ctrl) begin
            ctl_next.timeout_interrupt_enable = wdata[CTRL_IE];
            if (wdata[CTRL_FLAG]) begin
                ctl_next.flag = 1'b0;
            end
            if (second_wr) begin
                ctl_next.change_unlock_bit = 1'b0;
                ctl_next.period_select_bits = wr_period; // [R15]
                if (!level2) begin
                    ctl_next.watchdog_enable_bit = wdata[CTRL_EN]; // [R13]
                end
            end else begin
                if (open_seq) begin
                    ctl_next.change_unlock_bit = 1'b1;
                end
                if (wdata[CTRL_EN]) begin
                    ctl_next.watchdog_enable_bit = 1'b1; // [R12]
                end
                if (!level2) begin
                    ctl_next.period_select_bits = wr_period; // [R11]
                end
            end
        end
        // Hardware events come last so that they win over a software clear.
        if (timeout && (act == ACT_IRQ)) begin
            ctl_next.flag = 1'b1; // [R10]
        end
        if (timeout && en_eff && ctl_reg.timeout_interrupt_enable) begin
            ctl_next.timeout_interrupt_enable = 1'b0; // [R17]
        end
    end

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            ctl_reg <= wdctl_s'(RESET_VALUE);
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            ucnt_reg <= 2'h0;
        end else if (wr_ctrl && open_seq && !second_wr) begin
            ucnt_reg <= UNLOCK_LAST; // [R18]
        end else if (ctl_reg.change_unlock_bit && (ucnt_reg != 2'h0)) begin
            ucnt_reg <= ucnt_reg - 2'h1;
        end
    end

    // ****************************************
    // Brownout filter
    // ****************************************
    logic [BOD_W-1:0] bcnt_reg;
    logic bod_act_reg;
    logic bod_low;

    assign bod_low = fz.brownout_level_fuse && low_s;

    always_ff @(posedge clk) begin
        if (rst || !bod_low) begin
            bcnt_reg <= '0;
            bod_act_reg <= 1'b0; // [R3]
        end else if (bcnt_reg != BOD_LAST) begin
            bcnt_reg <= bcnt_reg + 7'h01; // [R4]
        end else begin
            bod_act_reg <= 1'b1; // [R3] [R4]
        end
    end

    // ****************************************
    // Reset combining and start-up delay
    // ****************************************
    logic ext_async;
    logic ext_low_s;
    logic src;
    logic [TOUT_W-1:0] tcnt_reg;

    // The raw pin presets the core reset so that no clock is needed.
    assign ext_async = fuses.ext_reset_en && !ext_reset_n; // [R1]
    assign ext_low_s = fz.ext_reset_en && !ext_n_s;
    assign src = rst || ext_low_s || bod_act_reg || wdt_pulse_reg; // [R21]

    always_ff @(posedge clk or posedge ext_async) begin
        if (ext_async) begin
            core_reset_reg <= 1'b1; // [R1]
            tcnt_reg <= TOUT_LAST;
        end else if (src) begin
            core_reset_reg <= 1'b1; // [R3] [R5] [R21]
            tcnt_reg <= TOUT_LAST;
        end else if (tcnt_reg != '0) begin
            tcnt_reg <= tcnt_reg - 12'h001; // [R2]
        end else begin
            core_reset_reg <= 1'b0; // [R2] [R21]
        end
    end

    // ****************************************
    // Read port and outputs
    // ****************************************
    logic [7:0] ctl_rd;
    logic [7:0] status_rd;
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;
    logic irq_reg;
    logic vref_reg;

    assign ctl_rd = {ctl_reg.flag, ctl_reg.timeout_interrupt_enable,
        ctl_reg.period_select_bits[3], ctl_reg.change_unlock_bit,
        en_eff, ctl_reg.period_select_bits[2:0]}; // [R14]
    assign status_rd = {5'h00, ext_low_s, bod_act_reg, core_reset_reg};
    assign rdata_next = !rd ? 8'h00 :
        (addr == ADDR_CTRL) ? ctl_rd :
        (addr == ADDR_STATUS) ? status_rd : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            vref_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            // The timeout that arms the reset also clears the interrupt
            // enable, so a set enable keeps that last request standing.
            irq_reg <= ctl_reg.flag
                && (ctl_reg.timeout_interrupt_enable || en_eff); // [R16]
            vref_reg <= fz.brownout_level_fuse || comparator_bandgap_select
                || converter_enable; // [R6]
        end
    end

    assign rdata = rdata_reg;
    assign core_reset = core_reset_reg;
    assign wdt_irq = irq_reg;
    assign vref_enable = vref_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence unlock_opened;
        $rose(ctl_reg.change_unlock_bit) && !wr_ctrl;
    endsequence

    sequence window_quiet;
        !wr_ctrl [*3];
    endsequence

    a_unlock_closes: assert property ( // [R18]
        unlock_opened ##1 window_quiet |=> !ctl_reg.change_unlock_bit)
        else $error("unlock bit did not close after four cycles");

    a_pulse_one_cycle: assert property ( // [R5]
        wdt_pulse_reg |=> !wdt_pulse_reg)
        else $error("watchdog reset pulse longer than one cycle");

    a_pulse_holds_core: assert property ( // [R5]
        wdt_pulse_reg |=> core_reset_reg && tcnt_reg == TOUT_LAST)
        else $error("watchdog pulse did not start the start-up delay");

    a_level2_reads_en: assert property ( // [R14]
        rd && addr == ADDR_CTRL && level2 |=> rdata[CTRL_EN])
        else $error("enable bit read as zero in level 2");

    a_disable_refused: assert property ( // [R13]
        wr_ctrl && !level2 && ctl_reg.watchdog_enable_bit
        && !ctl_reg.change_unlock_bit && !core_reset_reg
        |=> ctl_reg.watchdog_enable_bit)
        else $error("watchdog disabled without the unlock sequence");

    a_restart_clears: assert property ( // [R8]
        restart_wr |=> wcnt_reg == '0)
        else $error("restart did not clear the watchdog counter");

    a_core_release: assert property ( // [R21]
        $fell(core_reset_reg) |-> $past(tcnt_reg) == '0 && !$past(src))
        else $error("core released before the start-up delay ended");

    a_vref_follows: assert property ( // [R6]
        ##1 vref_reg == $past(fz.brownout_level_fuse
        || comparator_bandgap_select || converter_enable))
        else $error("reference enable does not follow its sources");

    a_ie_autoclear: assert property ( // [R17]
        timeout && en_eff && ctl_reg.timeout_interrupt_enable && !dev_rst
        |=> !ctl_reg.timeout_interrupt_enable)
        else $error("interrupt enable not cleared on timeout");

    a_bod_filter: assert property ( // [R4]
        $rose(bod_act_reg) |-> $past(bcnt_reg) == BOD_LAST)
        else $error("brownout accepted before the minimum duration");

endmodule
